// File: core/dcbs_top.sv
// DC braking sequencer with Avalon-MM register slave
`timescale 1ns/1ns
module dcbs_top #(
   parameter int P_TICK_CYCLES = dcbs_pkg::TICK_CYCLES
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_resetn,
   input  wire logic [7:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [31:0] i_writedata,
   output logic      [31:0] o_readdata,
   output logic             o_waitrequest,
   input  wire logic [31:0] i_speed_rpm,
   input  wire logic        i_fault_valid,
   input  wire logic [15:0] i_fault_number,
   input  wire logic        i_motor_induction,
   input  wire logic        i_brake_di,
   input  wire logic        i_ramp_stop_cmd,
   input  wire logic        i_quick_stop_cmd,
   input  wire logic        i_on_cmd,
   output logic             o_coast_stop_cmd,
   output logic             o_ramp_down,
   output logic      [15:0] o_brake_current,
   output logic             o_brake_active,
   output logic             o_torque_free,
   output logic             o_standstill_dc,
   output logic             o_motor_spinning
);
   localparam int NF = dcbs_pkg::N_FAULT;

   typedef struct packed {
      logic                  ack;
      logic [31:0]           rdata;
      logic                  act;
      logic                  src;
      logic [3:0]            cfg;
      logic [15:0]           cur;
      logic [15:0]           dur;
      logic [15:0]           deexc;
      logic [31:0]           start;
      logic [31:0]           rated;
      logic [2:0]            fly;
      logic [NF-1:0][15:0]   fnum;
      logic [NF-1:0][3:0]    fresp;
      dcbs_pkg::dcbs_state_t st;
      dcbs_pkg::dcbs_cause_t cause;
      logic                  armed;
      logic                  fault_pend;
      logic                  act_prev;
      logic                  on_prev;
      logic                  spin;
      logic [16:0]           tick;
      logic [15:0]           ms;
      logic [15:0]           iout;
   } dcbs_regs_t;

   // Reset image with the documented defaults
   function automatic dcbs_regs_t rst_val();
      dcbs_regs_t v;
      v       = '0;
      v.cur   = dcbs_pkg::RST_CURRENT;
      v.dur   = dcbs_pkg::RST_DURATION;
      v.start = dcbs_pkg::RST_START;
      v.deexc = dcbs_pkg::RST_DEEXC;
      v.rated = dcbs_pkg::RST_RATED;
      v.st    = dcbs_pkg::ST_RUN;
      v.cause = dcbs_pkg::CS_UNDER;
      return v;
   endfunction

   // Scan both fault tables for a braking response at a matching index
   function automatic logic fault_brakes(
      input logic [15:0]         num,
      input logic [NF-1:0][15:0] tnum,
      input logic [NF-1:0][3:0]  tresp
   );
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NF; i++) begin
         if (tnum[i] == num
             && tresp[i] == dcbs_pkg::DC_BRAKE_RESPONSE_TAG) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   localparam dcbs_regs_t RST_V = rst_val();

   dcbs_regs_t  r_q;
   dcbs_regs_t  r_d;
   logic [3:0]  pins_sync;
   logic        di_s;
   logic        ramp_s;
   logic        quick_s;
   logic        on_s;
   logic        act_eff;
   logic        stop_req;
   logic        cmd_rise;
   logic        under_req;
   logic        on_rise;
   logic        cancel;
   logic        dur_done;

   // Stop, on and digital input come from pins
   dcbs_sync3 #(.W(4)) u_sync (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .i_async    ({i_on_cmd, i_quick_stop_cmd, i_ramp_stop_cmd, i_brake_di}),
      .o_sync     (pins_sync)
   );
   assign di_s    = pins_sync[0];
   assign ramp_s  = pins_sync[1];
   assign quick_s = pins_sync[2];
   assign on_s    = pins_sync[3];

   // Trigger decode shared by the sequencer and the checks
   always_comb begin
      act_eff   = r_q.src ? di_s : r_q.act;
      stop_req  = (ramp_s | quick_s) && (r_q.cfg == dcbs_pkg::CFG_STOP
                  || (r_q.cfg == dcbs_pkg::CFG_GEN && act_eff));
      cmd_rise  = r_q.cfg == dcbs_pkg::CFG_GEN && act_eff && !r_q.act_prev;
      under_req = r_q.cfg == dcbs_pkg::CFG_UNDER && act_eff && r_q.armed
                  && i_speed_rpm < r_q.start;
      on_rise   = on_s && !r_q.on_prev;
      cancel    = !act_eff && (r_q.cause == dcbs_pkg::CS_UNDER
                  || r_q.cause == dcbs_pkg::CS_CMD);
      dur_done  = r_q.ms >= r_q.dur;
   end

   // Bus slave, settings, fault latch and the braking sequence
   always_comb begin
      r_d          = r_q;
      r_d.ack      = (i_read | i_write) & !r_q.ack;
      r_d.act_prev = act_eff;
      r_d.on_prev  = on_s;

      // Read data is captured one cycle ahead of the answer
      if (i_read && !r_q.ack) begin
         r_d.rdata = 32'h0000_0000;
         unique case (i_address)
            dcbs_pkg::A_CTRL: begin
               r_d.rdata[dcbs_pkg::CTRL_ACT_BIT] = r_q.act;
               r_d.rdata[dcbs_pkg::CTRL_SRC_BIT] = r_q.src;
            end
            dcbs_pkg::A_CONFIG:   r_d.rdata[3:0]  = r_q.cfg;
            dcbs_pkg::A_CURRENT:  r_d.rdata[15:0] = r_q.cur;
            dcbs_pkg::A_DURATION: r_d.rdata[15:0] = r_q.dur;
            dcbs_pkg::A_START:    r_d.rdata       = r_q.start;
            dcbs_pkg::A_DEEXC:    r_d.rdata[15:0] = r_q.deexc;
            dcbs_pkg::A_STATUS: begin
               r_d.rdata[2:0] = r_q.st;
               r_d.rdata[dcbs_pkg::STATUS_ACT_BIT]  = act_eff;
               r_d.rdata[dcbs_pkg::STATUS_SPIN_BIT] = r_q.spin;
            end
            dcbs_pkg::A_FLY:      r_d.rdata[2:0]  = r_q.fly;
            dcbs_pkg::A_RATED:    r_d.rdata       = r_q.rated;
            default: begin
               for (int i = 0; i < NF; i++) begin
                  if (i_address == dcbs_pkg::A_FNUM + 8'(4 * i)) begin
                     r_d.rdata[15:0] = r_q.fnum[i];
                  end
                  if (i_address == dcbs_pkg::A_FRESP + 8'(4 * i)) begin
                     r_d.rdata[3:0] = r_q.fresp[i];
                  end
               end
            end
         endcase
      end

      // Writes land on the edge where waitrequest is low
      if (i_write && r_q.ack) begin
         unique case (i_address)
            dcbs_pkg::A_CTRL: begin
               r_d.act = i_writedata[dcbs_pkg::CTRL_ACT_BIT];
               r_d.src = i_writedata[dcbs_pkg::CTRL_SRC_BIT];
            end
            dcbs_pkg::A_CONFIG: begin
               if (i_motor_induction) begin
                  r_d.cfg = i_writedata[3:0];
               end
            end
            dcbs_pkg::A_CURRENT:  r_d.cur   = i_writedata[15:0];
            dcbs_pkg::A_DURATION: r_d.dur   = i_writedata[15:0];
            dcbs_pkg::A_START:    r_d.start = i_writedata;
            dcbs_pkg::A_DEEXC:    r_d.deexc = i_writedata[15:0];
            dcbs_pkg::A_FLY:      r_d.fly   = i_writedata[2:0];
            dcbs_pkg::A_RATED:    r_d.rated = i_writedata;
            default: begin
               for (int i = 0; i < NF; i++) begin
                  if (i_address == dcbs_pkg::A_FNUM + 8'(4 * i)) begin
                     r_d.fnum[i] = i_writedata[15:0];
                  end
                  if (i_address == dcbs_pkg::A_FRESP + 8'(4 * i)) begin
                     r_d.fresp[i] = i_writedata[3:0];
                  end
               end
            end
         endcase
      end
      // Any other motor type keeps the function switched off
      if (!i_motor_induction) begin
         r_d.cfg = dcbs_pkg::CFG_NONE;
      end

      // Undershoot arms only after speed has been above the threshold
      if (i_speed_rpm > r_q.start) begin
         r_d.armed = 1'b1;
      end

      unique case (r_q.st)
         dcbs_pkg::ST_RUN: begin
            if (r_q.fault_pend) begin
               r_d.st    = dcbs_pkg::ST_RAMP;
               r_d.cause = dcbs_pkg::CS_FAULT;
            end else if (stop_req) begin
               r_d.st    = dcbs_pkg::ST_RAMP;
               r_d.cause = dcbs_pkg::CS_STOP;
            end else if (cmd_rise) begin
               r_d.st    = dcbs_pkg::ST_DEEXC;
               r_d.cause = dcbs_pkg::CS_CMD;
            end else if (under_req) begin
               r_d.st    = dcbs_pkg::ST_DEEXC;
               r_d.cause = dcbs_pkg::CS_UNDER;
               r_d.armed = 1'b0;
            end else if (on_rise && r_q.fly != 3'h0) begin
               r_d.st = dcbs_pkg::ST_FLY;
            end
         end
         dcbs_pkg::ST_RAMP: begin
            if (i_speed_rpm <= r_q.start) begin
               r_d.st = dcbs_pkg::ST_DEEXC;
            end
         end
         dcbs_pkg::ST_DEEXC: begin
            if (cancel) begin
               r_d.st = dcbs_pkg::ST_RUN;
            end else if (r_q.ms >= r_q.deexc) begin
               r_d.st = dcbs_pkg::ST_BRAKE;
            end
         end
         dcbs_pkg::ST_BRAKE: begin
            if (cancel) begin
               r_d.st = dcbs_pkg::ST_RUN;
            end else if (dur_done) begin
               if (r_q.cause == dcbs_pkg::CS_STOP
                   || r_q.cause == dcbs_pkg::CS_FAULT) begin
                  r_d.st = dcbs_pkg::ST_COAST;
               end else begin
                  r_d.st = dcbs_pkg::ST_RUN;
               end
            end
         end
         dcbs_pkg::ST_COAST: begin
            if (on_rise) begin
               r_d.st = (r_q.fly != 3'h0) ? dcbs_pkg::ST_FLY
                                          : dcbs_pkg::ST_RUN;
            end
         end
         dcbs_pkg::ST_FLY: begin
            if (r_q.ms >= 16'(dcbs_pkg::FLY_CHECK_MS)) begin
               r_d.spin = i_speed_rpm
                          > r_q.rated / 32'(dcbs_pkg::FLY_FRAC_DIV);
               r_d.st   = dcbs_pkg::ST_RUN;
            end
         end
         default: r_d.st = dcbs_pkg::ST_RUN;
      endcase

      // Fault latch: a new match wins over the consuming clear
      if (r_q.st == dcbs_pkg::ST_RUN && r_q.fault_pend) begin
         r_d.fault_pend = 1'b0;
      end
      if (i_fault_valid && r_q.cfg != dcbs_pkg::CFG_NONE
          && fault_brakes(i_fault_number, r_q.fnum, r_q.fresp)) begin
         r_d.fault_pend = 1'b1;
      end

      // Millisecond timer restarts on every state change
      if (r_d.st != r_q.st) begin
         r_d.tick = '0;
         r_d.ms   = '0;
      end else if (r_q.tick == 17'(P_TICK_CYCLES - 1)) begin
         r_d.tick = '0;
         if (r_q.ms != 16'hFFFF) begin
            r_d.ms = r_q.ms + 16'h0001;
         end
      end else begin
         r_d.tick = r_q.tick + 17'h0_0001;
      end

      // Current flows only in the braking phase, never in de-excitation
      r_d.iout = (r_d.st == dcbs_pkg::ST_BRAKE) ? r_q.cur
                                                 : 16'h0000;
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         r_q <= RST_V;
      end else begin
         r_q <= r_d;
      end
   end

   // Answer after one wait cycle; read data is already registered
   assign o_waitrequest    = (i_read | i_write) & !r_q.ack;
   assign o_readdata       = r_q.rdata;
   assign o_brake_current  = r_q.iout;
   assign o_brake_active   = r_q.st == dcbs_pkg::ST_BRAKE;
   assign o_ramp_down      = r_q.st == dcbs_pkg::ST_RAMP;
   assign o_coast_stop_cmd = r_q.st == dcbs_pkg::ST_DEEXC
                             || r_q.st == dcbs_pkg::ST_COAST;
   assign o_torque_free    = r_q.st == dcbs_pkg::ST_COAST;
   assign o_standstill_dc  = r_q.st == dcbs_pkg::ST_FLY;
   assign o_motor_spinning = r_q.spin;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);

   AST_CUR_ZERO: assert property (
      (o_brake_current != 16'h0000) |-> o_brake_active)
      else $error("brake current outside braking phase");
   AST_READBACK: assert property (
      (i_read && !r_q.ack && i_address == dcbs_pkg::A_STATUS)
      |=> o_readdata[dcbs_pkg::STATUS_ACT_BIT] == $past(act_eff))
      else $error("status bit 11 does not mirror activation");
   AST_DEEXC_FIRST: assert property (
      $rose(o_brake_active) |-> $past(r_q.st) == dcbs_pkg::ST_DEEXC)
      else $error("braking entered without de-excitation");
   AST_FAULT_RAMP: assert property (
      (r_q.st == dcbs_pkg::ST_RUN && r_q.fault_pend)
      |=> o_ramp_down && r_q.cause == dcbs_pkg::CS_FAULT)
      else $error("fault response did not start ramp");
   AST_CMD_START: assert property (
      (r_q.st == dcbs_pkg::ST_RUN && !r_q.fault_pend && !stop_req
       && cmd_rise)
      |=> r_q.st == dcbs_pkg::ST_DEEXC ##1 o_coast_stop_cmd)
      else $error("command did not start braking");
   AST_CMD_WITHDRAW: assert property (
      (o_brake_active && r_q.cause == dcbs_pkg::CS_CMD && !act_eff)
      |=> r_q.st == dcbs_pkg::ST_RUN && o_brake_current == 16'h0000)
      else $error("withdrawn command kept braking");
   AST_STOP_COAST: assert property (
      (o_brake_active && r_q.cause == dcbs_pkg::CS_STOP && dur_done)
      |=> o_torque_free)
      else $error("stop braking did not end in coast");
   AST_UNDER_ARM: assert property (
      (r_q.st == dcbs_pkg::ST_RUN && !r_q.armed)
      |=> !(r_q.st == dcbs_pkg::ST_DEEXC
            && r_q.cause == dcbs_pkg::CS_UNDER))
      else $error("undershoot braking without prior overshoot");
   AST_CFG_INDUCT: assert property (
      !i_motor_induction |=> r_q.cfg == dcbs_pkg::CFG_NONE)
      else $error("braking configured for non-induction motor");
endmodule

// File: core/dcbs_pkg.sv
// Constants, register map and types of the DC braking sequencer
package dcbs_pkg;
   // Core clock and time base
   localparam int CLK_HZ        = 125_000_000;
   localparam int TICK_MS       = 1;
   localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
   localparam int FLY_CHECK_MS  = 1000;
   localparam int FLY_FRAC_DIV  = 10;

   // Register byte offsets
   localparam logic [7:0] A_CTRL     = 8'h00;
   localparam logic [7:0] A_CONFIG   = 8'h04;
   localparam logic [7:0] A_CURRENT  = 8'h08;
   localparam logic [7:0] A_DURATION = 8'h0C;
   localparam logic [7:0] A_START    = 8'h10;
   localparam logic [7:0] A_DEEXC    = 8'h14;
   localparam logic [7:0] A_STATUS   = 8'h18;
   localparam logic [7:0] A_FLY      = 8'h1C;
   localparam logic [7:0] A_RATED    = 8'h20;
   localparam logic [7:0] A_FNUM     = 8'h40;
   localparam logic [7:0] A_FRESP    = 8'h60;

   // Field positions
   localparam int CTRL_ACT_BIT    = 0;
   localparam int CTRL_SRC_BIT    = 1;
   localparam int STATUS_ACT_BIT  = 11;
   localparam int STATUS_SPIN_BIT = 12;

   // Reset values
   localparam logic [15:0] RST_CURRENT  = 16'h0000;
   localparam logic [15:0] RST_DURATION = 16'h03E8;
   localparam logic [31:0] RST_START    = 32'h0003_3450;
   localparam logic [15:0] RST_DEEXC    = 16'h0064;
   localparam logic [31:0] RST_RATED    = 32'h0000_05DC;

   // Braking configuration codes
   localparam logic [3:0] CFG_NONE  = 4'h0;
   localparam logic [3:0] CFG_GEN   = 4'h4;
   localparam logic [3:0] CFG_STOP  = 4'h5;
   localparam logic [3:0] CFG_UNDER = 4'hE;

   // Fault table
   localparam int         N_FAULT              = 8;
   localparam logic [3:0] DC_BRAKE_RESPONSE_TAG = 4'h6;

   typedef enum logic [2:0] {
      ST_RUN, ST_RAMP, ST_DEEXC, ST_BRAKE, ST_COAST, ST_FLY
   } dcbs_state_t;

   typedef enum logic [1:0] {
      CS_UNDER, CS_CMD, CS_FAULT, CS_STOP
   } dcbs_cause_t;
endpackage

// File: core/dcbs_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module dcbs_sync3 #(
   parameter int W = 4
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_resetn,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } dcbs_sync_regs_t;

   dcbs_sync_regs_t r_q;
   dcbs_sync_regs_t r_d;

   // A bit moves only when stages two and three agree; stage one
   // feeds stage two alone so metastability stays contained
   always_comb begin
      r_d     = r_q;
      r_d.s1  = i_async;
      r_d.s2  = r_q.s1;
      r_d.s3  = r_q.s2;
      r_d.out = (r_q.s2 & r_q.s3) | (r_q.out & (r_q.s2 | r_q.s3));
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign o_sync = r_q.out;
endmodule

// File: bench/dcbs_motor_model.sv
// Behavioural induction motor and speed estimate for the braking sequencer
`timescale 1ns/1ns
module dcbs_motor_model #(
   parameter int P_STEP  = 50,
   parameter int P_BRAKE = 20
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_resetn,
   input  wire logic [31:0] i_target_rpm,
   input  wire logic        i_coast,
   input  wire logic        i_ramp_down,
   input  wire logic        i_brake_active,
   input  wire logic [15:0] i_brake_current,
   output logic      [31:0] o_speed_rpm
);
   // Coasting keeps the rotor turning, so speed only moves when driven
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_speed_rpm <= 32'h0000_0000;
      end else if (i_brake_active && i_brake_current != 16'h0000) begin
         o_speed_rpm <= (o_speed_rpm > 32'(P_BRAKE)) ?
                        o_speed_rpm - 32'(P_BRAKE) : 32'h0000_0000;
      end else if (i_ramp_down) begin
         o_speed_rpm <= (o_speed_rpm > 32'(P_STEP)) ?
                        o_speed_rpm - 32'(P_STEP) : 32'h0000_0000;
      end else if (!i_coast && o_speed_rpm + 32'(P_STEP) <= i_target_rpm) begin
         o_speed_rpm <= o_speed_rpm + 32'(P_STEP);
      end else if (!i_coast && o_speed_rpm > i_target_rpm) begin
         // A lower setpoint is approached at the same slope as a rise
         o_speed_rpm <= (o_speed_rpm > i_target_rpm + 32'(P_STEP)) ?
                        o_speed_rpm - 32'(P_STEP) : i_target_rpm;
      end
   end
endmodule

// File: bench/testbench.sv
// Self-checking bench for the DC braking sequencer
`timescale 1ns/1ns
module testbench;
   localparam int P_TICK = 10;
   logic        clk, rstn, rd_s, wr_s, waitreq, flt_v, induct, brake_di;
   logic        ramp_stop, quick_stop, on_cmd, coast, ramp, brk, tfree;
   logic        sdc, spin;
   logic [7:0]  addr;
   logic [15:0] flt_n, cur;
   logic [31:0] wdata, rdata, speed, target;
   int          fail_count;
   int          n_compared;

   dcbs_top #(.P_TICK_CYCLES(P_TICK)) u_dut (
      .i_core_clk(clk), .i_resetn(rstn), .i_address(addr), .i_read(rd_s),
      .i_write(wr_s), .i_writedata(wdata), .o_readdata(rdata),
      .o_waitrequest(waitreq), .i_speed_rpm(speed), .i_fault_valid(flt_v),
      .i_fault_number(flt_n), .i_motor_induction(induct),
      .i_brake_di(brake_di), .i_ramp_stop_cmd(ramp_stop),
      .i_quick_stop_cmd(quick_stop), .i_on_cmd(on_cmd),
      .o_coast_stop_cmd(coast), .o_ramp_down(ramp), .o_brake_current(cur),
      .o_brake_active(brk), .o_torque_free(tfree), .o_standstill_dc(sdc),
      .o_motor_spinning(spin));

   dcbs_motor_model u_motor (
      .i_core_clk(clk), .i_resetn(rstn), .i_target_rpm(target),
      .i_coast(coast | tfree | sdc), .i_ramp_down(ramp),
      .i_brake_active(brk), .i_brake_current(cur), .o_speed_rpm(speed));

   // Free-running core clock
   always #4 clk = ~clk;

   // One Avalon transfer; request held until waitrequest is seen low
   task automatic bus(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= we;
      rd_s  <= !we;
      // Only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      q = rdata;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0000_0000, q);
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_rng(input string nm, input int lo, input int hi,
                          input int g);
      n_compared++;
      if (g < lo || g > hi) begin
         fail_count++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   function automatic logic sig(input int k);
      case (k)
         0: return coast;
         1: return ramp;
         2: return brk;
         3: return tfree;
         default: return sdc;
      endcase
   endfunction

   // Counts cycles until an output takes a value; a timeout returns mx
   task automatic wait_sig(input int k, input logic v, input int mx,
                           output int n);
      n = 0;
      @(negedge clk);
      while (sig(k) !== v && n < mx) begin
         @(negedge clk);
         n++;
      end
   endtask

   // Fault event is a one-cycle pulse
   task automatic fault(input logic [15:0] num);
      @(posedge clk);
      flt_v <= 1'b1;
      flt_n <= num;
      @(posedge clk);
      flt_v <= 1'b0;
   endtask

   task automatic t_regs();
      logic [31:0] cd [4] = '{32'h0000_0004, 32'h0000_0005,
                              32'h0000_000E, 32'h0000_0000};
      logic [31:0] q;
      int n;
      rd(dcbs_pkg::A_CURRENT, q);
      chk("cur_rst", 32'h0000_0000, q);
      rd(dcbs_pkg::A_DURATION, q);
      chk("dur_rst", 32'h0000_03E8, q);
      rd(dcbs_pkg::A_START, q);
      chk("start_rst", 32'h0003_3450, q);
      rd(8'hFC, q);
      chk("unmapped", 32'h0000_0000, q);
      wr(dcbs_pkg::A_CONFIG, 32'h0000_0004);
      rd(dcbs_pkg::A_CONFIG, q);
      chk("cfg_not_induction", 32'h0000_0000, q);
      induct <= 1'b1;
      foreach (cd[i]) begin
         wr(dcbs_pkg::A_CONFIG, cd[i]);
         rd(dcbs_pkg::A_CONFIG, q);
         chk("cfg", cd[i], q);
      end
      wr(dcbs_pkg::A_CTRL, 32'h0000_0001);
      wait_sig(0, 1'b1, 30, n);
      chk_rng("cfg_off_idle", 30, 30, n);
      wr(dcbs_pkg::A_CTRL, 32'h0000_0000);
   endtask

   task automatic t_cmd();
      logic [31:0] q;
      int n;
      wr(dcbs_pkg::A_CURRENT, 32'h0000_0123);
      wr(dcbs_pkg::A_DURATION, 32'h0000_0002);
      wr(dcbs_pkg::A_DEEXC, 32'h0000_0001);
      wr(dcbs_pkg::A_CONFIG, 32'h0000_0004);
      wr(dcbs_pkg::A_CTRL, 32'h0000_0001);
      wait_sig(0, 1'b1, 10, n);
      chk_rng("cmd_start", 0, 3, n);
      chk("cur_deexc", 32'h0000_0000, 32'(cur));
      wait_sig(2, 1'b1, 30, n);
      chk_rng("deexc_cycles", 8, 12, n);
      chk("cur_brake", 32'h0000_0123, 32'(cur));
      wait_sig(2, 1'b0, 40, n);
      chk_rng("brake_cycles", 18, 22, n);
      rd(dcbs_pkg::A_STATUS, q);
      chk("status_act_1", 32'h0000_0001, 32'(q[11]));
      wr(dcbs_pkg::A_DURATION, 32'h0000_0032);
      wr(dcbs_pkg::A_CTRL, 32'h0000_0000);
      wr(dcbs_pkg::A_CTRL, 32'h0000_0001);
      wait_sig(2, 1'b1, 40, n);
      wr(dcbs_pkg::A_CTRL, 32'h0000_0000);
      wait_sig(2, 1'b0, 6, n);
      chk_rng("withdraw", 0, 5, n);
      chk("coast_withdraw", 32'h0000_0000, 32'(coast));
      rd(dcbs_pkg::A_STATUS, q);
      chk("status_act_0", 32'h0000_0000, 32'(q[11]));
      wr(dcbs_pkg::A_CTRL, 32'h0000_0002);
      brake_di <= 1'b1;
      wait_sig(0, 1'b1, 10, n);
      chk_rng("pin_activate", 0, 8, n);
      @(posedge clk);
      brake_di <= 1'b0;
      wait_sig(0, 1'b0, 10, n);
      wr(dcbs_pkg::A_CTRL, 32'h0000_0000);
   endtask

   task automatic t_under();
      int n;
      wr(dcbs_pkg::A_START, 32'h0000_03E8);
      wr(dcbs_pkg::A_CONFIG, 32'h0000_000E);
      target <= 32'h0000_01F4;
      wr(dcbs_pkg::A_CTRL, 32'h0000_0001);
      wait_sig(0, 1'b1, 60, n);
      chk_rng("not_armed", 60, 60, n);
      @(posedge clk);
      target <= 32'h0000_07D0;
      repeat (50) @(posedge clk);
      target <= 32'h0000_0000;
      wait_sig(0, 1'b1, 60, n);
      chk_rng("undershoot", 17, 26, n);
      wait_sig(2, 1'b1, 20, n);
      wr(dcbs_pkg::A_CTRL, 32'h0000_0000);
      wait_sig(2, 1'b0, 6, n);
      chk_rng("under_cancel", 0, 5, n);
   endtask

   task automatic t_stop(input int k);
      int n;
      wr(dcbs_pkg::A_DURATION, 32'h0000_0002);
      wr(dcbs_pkg::A_CONFIG, 32'h0000_0005);
      wr(dcbs_pkg::A_FLY, 32'h0000_0001);
      target <= 32'h0000_07D0;
      repeat (50) @(posedge clk);
      ramp_stop <= (k == 0);
      quick_stop <= (k != 0);
      wait_sig(1, 1'b1, 10, n);
      chk_rng("stop_ramp", 0, 8, n);
      wait_sig(0, 1'b1, 40, n);
      chk_rng("ramp_to_start", 15, 25, n);
      wait_sig(3, 1'b1, 60, n);
      chk_rng("torque_free", 26, 34, n);
      chk("cur_coast", 32'h0000_0000, 32'(cur));
      @(posedge clk);
      ramp_stop <= 1'b0;
      quick_stop <= 1'b0;
      on_cmd <= 1'b1;
      wait_sig(4, 1'b1, 10, n);
      chk("cur_check", 32'h0000_0000, 32'(cur));
      wait_sig(4, 1'b0, 10100, n);
      chk_rng("dc_check_cycles", 9990, 10010, n);
      chk("spinning", 32'h0000_0001, 32'(spin));
      @(posedge clk);
      on_cmd <= 1'b0;
   endtask

   task automatic t_fault();
      int n;
      wr(dcbs_pkg::A_FLY, 32'h0000_0000);
      wr(dcbs_pkg::A_CONFIG, 32'h0000_0004);
      wr(dcbs_pkg::A_FNUM + 8'h08, 32'h0000_0042);
      wr(dcbs_pkg::A_FRESP + 8'h08, 32'h0000_0002);
      wr(dcbs_pkg::A_FNUM + 8'h0C, 32'h0000_1EB4);
      wr(dcbs_pkg::A_FRESP + 8'h0C, 32'h0000_0006);
      repeat (50) @(posedge clk);
      fault(16'h0042);
      wait_sig(1, 1'b1, 20, n);
      chk_rng("fault_other", 20, 20, n);
      fault(16'h1EB4);
      wait_sig(1, 1'b1, 5, n);
      chk_rng("fault_ramp", 0, 3, n);
      wait_sig(0, 1'b1, 40, n);
      chk_rng("fault_to_start", 15, 25, n);
      wait_sig(2, 1'b1, 20, n);
      chk("fault_brake", 32'h0000_0123, 32'(cur));
   endtask

   task automatic summarize();
      if (fail_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      {clk, rstn, rd_s, wr_s, flt_v, induct, brake_di} = 7'h00;
      {ramp_stop, quick_stop, on_cmd} = 3'h0;
      addr = 8'h00;
      flt_n = 16'h0000;
      wdata = 32'h0000_0000;
      target = 32'h0000_0000;
      fail_count = 0;
      n_compared = 0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_cmd();
      t_under();
      t_stop(0);
      t_stop(1);
      t_fault();
      summarize();
   end

   // Watchdog well beyond the two long standstill checks
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      summarize();
   end
endmodule
